// [design/iprc_consts.svh]
// Constants for the interrupt mask and priority control block
// ============================================================
// Operation
// - A source whose mask flag is 1 is never offered for acknowledgment.
// - A source whose mask flag is 0 may be taken as vectored or macro service.
// - Mask words are 16 bits, written as word, low byte, high byte or single bit.
// - Mask word bits and per-source mask flags are one storage; both views change it.
// - Reset loads both mask words with FFFFH, masking every source.
// - Maskable acknowledgment sets the in-service bit of its level until return.
// - Non-maskable acknowledgment sets that source's in-service bit until return.
// - Vectored or hardware switch return clears only the highest set in-service bit.
// - Break return and software switch return leave in-service bits unchanged.
// - In-service register is read-only and resets to 00H.
// - Mode control holds the lowest-level nesting flag, resets to 80H; DI first.
// - A watchdog mode bit orders pin and watchdog non-maskable sources.
// - Watchdog mode is written only by the 4-byte move with complemented bytes.
// - Failed complement check suppresses write, raises operand error at instruction start.
// - Other writes to watchdog mode change nothing and raise no interrupt.
// - Watchdog mode reads anytime and resets to 00H.
// - Vectored entry or break pushes status low and clears enable; returns restore.
// - Context switch entries save status low in bank, clear enable; returns restore.
// - Reset clears status low to 00H, disabling maskable interrupts.
// - Break and software switch instructions are taken regardless of mask or enable.
// - Break pushes status and PC, clears enable, vectors via 003EH with top nibble 0.
// - Software switch branches via the selected bank and saves status and PC there.
// - Priority field 00 to 11 maps to level 0 (highest) to 3 (lowest).
`ifndef IPRC_CONSTS_SVH
`define IPRC_CONSTS_SVH

// ============================================================
// Register selectors on the core access port
`define IPRC_SEL_MK0 3'h0
`define IPRC_SEL_MK1 3'h1
`define IPRC_SEL_IN_SERVICE_LEVEL 3'h2
`define IPRC_SEL_IMC 3'h3
`define IPRC_SEL_WDM 3'h4
`define IPRC_SEL_STATUS_WORD_LOW 3'h5

// ============================================================
// Reset values
`define IPRC_MK_RESET 16'hFFFF
`define IPRC_IN_SERVICE_LEVEL_RESET 8'h00
`define IPRC_IMC_RESET 8'h80
`define IPRC_WDM_RESET 8'h00
`define IPRC_STATUS_WORD_LOW_RESET 8'h00

// ============================================================
// Field positions and vectors
`define IPRC_NEST_BIT 7
`define IPRC_PRC_BIT 4
`define IPRC_IE_BIT 5
`define IPRC_NMIS_BIT 7
`define IPRC_WDTS_BIT 6
`define IPRC_BRK_VECTOR 16'h003E
`define IPRC_BRK_PC_HIGH 4'h0

`endif

// [design/iprc_pkg.sv]
// Types shared by the interrupt mask and priority control block
package iprc_pkg;

  // ============================================================
  // Write forms on the core access port
  typedef enum logic [1:0] {
    WK_WORD = 2'b00,
    WK_LOW = 2'b01,
    WK_HIGH = 2'b10,
    WK_BIT = 2'b11
  } iprc_wkind_t;

  // ============================================================
  // Return and restore instruction kinds
  typedef enum logic [2:0] {
    RK_VEC = 3'b000,
    RK_HW_CS = 3'b001,
    RK_BRK = 3'b010,
    RK_SW_CS = 3'b011,
    RK_POP = 3'b100
  } iprc_ret_t;

endpackage

// [design/iprc_top.sv]
// Interrupt mask, in-service priority, mode, watchdog mode and status-low control
`timescale 1ns/1ps
`include "iprc_consts.svh"

module iprc_top (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic sfr_wr_i,
  input wire logic [2:0] sfr_sel_i,
  input wire iprc_pkg::iprc_wkind_t sfr_kind_i,
  input wire logic [3:0] sfr_bit_i,
  input wire logic [15:0] sfr_wdata_i,
  output logic [15:0] sfr_rdata_o,
  input wire logic mask_src_wr_i,
  input wire logic [4:0] mask_src_idx_i,
  input wire logic mask_src_val_i,
  input wire logic [31:0] irq_req_i,
  output logic [31:0] irq_eligible_o,
  input wire logic ack_mask_i,
  input wire logic [1:0] ack_level_i,
  input wire logic ack_cs_i,
  input wire logic ack_nmi_i,
  input wire logic ack_nmi_wdt_i,
  input wire logic brk_i,
  input wire logic software_context_switch_instruction_i,
  input wire logic [2:0] software_context_switch_instruction_bank_i,
  input wire logic ret_i,
  input wire iprc_pkg::iprc_ret_t ret_kind_i,
  input wire logic [7:0] restore_data_i,
  input wire logic wdm_ded_i,
  input wire logic [7:0] wdm_op3_i,
  input wire logic [7:0] wdm_op4_i,
  input wire logic [19:0] instr_addr_i,
  output logic [7:0] in_service_level_o,
  output logic nest_lowest_o,
  output logic nmi_order_o,
  output logic ie_o,
  output logic psw_push_o,
  output logic psw_bank_save_o,
  output logic [7:0] psw_save_data_o,
  output logic [2:0] bank_sel_o,
  output logic vector_load_o,
  output logic [15:0] vector_addr_o,
  output logic [3:0] pc_high_o,
  output logic op_err_o,
  output logic [19:0] op_err_pc_o
);
  import iprc_pkg::*;

  // ============================================================
  // Helpers
  function automatic logic [15:0] iprc_merge(input logic [15:0] old, input iprc_wkind_t k,
                                             input logic [3:0] b, input logic [15:0] d);
    logic [15:0] r;
    r = old;
    case (k)
      WK_WORD: r = d;
      WK_LOW: r[7:0] = d[7:0];
      WK_HIGH: r[15:8] = d[7:0];
      WK_BIT: r[b] = d[0];
      default: r = old;
    endcase
    return r;
  endfunction

  // Highest-priority set bit; the non-maskable pair outranks all maskable levels
  function automatic logic [7:0] iprc_top_bit(input logic [7:0] s, input logic nonmaskable_order_select);
    logic [7:0] r;
    r = 8'h00;
    if (nonmaskable_order_select && s[`IPRC_WDTS_BIT]) begin
      r[`IPRC_WDTS_BIT] = 1'b1;
    end else if (s[`IPRC_NMIS_BIT]) begin
      r[`IPRC_NMIS_BIT] = 1'b1;
    end else if (s[`IPRC_WDTS_BIT]) begin
      r[`IPRC_WDTS_BIT] = 1'b1;
    end else if (s[0]) begin
      r[0] = 1'b1;
    end else if (s[1]) begin
      r[1] = 1'b1;
    end else if (s[2]) begin
      r[2] = 1'b1;
    end else if (s[3]) begin
      r[3] = 1'b1;
    end
    return r;
  endfunction

  // ============================================================
  // State
  logic [31:0] mask_reg;
  logic [7:0] in_service_level_reg;
  logic [7:0] imc_reg;
  logic [7:0] wdm_reg;
  logic [7:0] status_word_low_reg;
  logic [31:0] mask_next;
  logic [7:0] in_service_level_next;
  logic [7:0] imc_next;
  logic [7:0] wdm_next;
  logic [7:0] status_word_low_next;
  logic [15:0] rdata_next;

  // ============================================================
  // Decode
  wire wr_mk0 = sfr_wr_i && (sfr_sel_i == `IPRC_SEL_MK0);
  wire wr_mk1 = sfr_wr_i && (sfr_sel_i == `IPRC_SEL_MK1);
  wire wr_imc = sfr_wr_i && (sfr_sel_i == `IPRC_SEL_IMC);
  wire wr_status_word_low = sfr_wr_i && (sfr_sel_i == `IPRC_SEL_STATUS_WORD_LOW);
  wire [15:0] mk0_w = iprc_merge(mask_reg[15:0], sfr_kind_i, sfr_bit_i, sfr_wdata_i);
  wire [15:0] mk1_w = iprc_merge(mask_reg[31:16], sfr_kind_i, sfr_bit_i, sfr_wdata_i);
  wire [15:0] imc_w = iprc_merge({8'h00, imc_reg}, sfr_kind_i, sfr_bit_i, sfr_wdata_i);
  wire [15:0] status_word_low_w = iprc_merge({8'h00, status_word_low_reg}, sfr_kind_i, sfr_bit_i, sfr_wdata_i);
  wire [31:0] mask_view = {wr_mk1 ? mk1_w : mask_reg[31:16], wr_mk0 ? mk0_w : mask_reg[15:0]};

  // ============================================================
  // Mask storage: one flop per source serves both views
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_mask
      assign mask_next[gi] = (mask_src_wr_i && mask_src_idx_i == 5'(gi)) ?
                             mask_src_val_i : mask_view[gi];
    end
  endgenerate

  // Masked sources are withheld; macro service and vectored use the same gate
  wire [31:0] eligible_next = irq_req_i & ~mask_reg;

  // ============================================================
  // In-service levels: set wins over the return clear in the same cycle
  wire [7:0] lvl_set = ack_mask_i ? (8'h01 << ack_level_i) : 8'h00;
  wire [7:0] nmi_set = !ack_nmi_i ? 8'h00 :
                       (ack_nmi_wdt_i ? (8'h01 << `IPRC_WDTS_BIT) :
                                        (8'h01 << `IPRC_NMIS_BIT));
  wire ret_clears = ret_i && (ret_kind_i == RK_VEC || ret_kind_i == RK_HW_CS);
  wire [7:0] in_service_level_clr = ret_clears ? iprc_top_bit(in_service_level_reg, wdm_reg[`IPRC_PRC_BIT]) : 8'h00;
  // Software writes never reach this register
  assign in_service_level_next = (in_service_level_reg & ~in_service_level_clr) | lvl_set | nmi_set;

  // ============================================================
  // Mode control and watchdog mode
  assign imc_next = wr_imc ? imc_w[7:0] : imc_reg;
  wire wdm_match = (wdm_op3_i == ~wdm_op4_i);
  // Only the dedicated move reaches the register; ordinary writes fall away
  assign wdm_next = (wdm_ded_i && wdm_match) ? wdm_op3_i : wdm_reg;
  wire op_err_next = wdm_ded_i && !wdm_match;

  // ============================================================
  // Status low: entry clear beats restore, restore beats a plain write
  wire vec_entry = ack_mask_i && !ack_cs_i;
  wire cs_entry = ack_mask_i && ack_cs_i;
  wire push_next = vec_entry || brk_i;
  wire bank_next = cs_entry || software_context_switch_instruction_i;
  wire entry_any = push_next || bank_next;
  wire [7:0] status_word_low_clr_ie = status_word_low_reg & ~(8'h01 << `IPRC_IE_BIT);
  always_comb begin
    status_word_low_next = status_word_low_reg;
    if (entry_any) begin
      status_word_low_next = status_word_low_clr_ie;
    end else if (ret_i) begin
      status_word_low_next = restore_data_i;
    end else if (wr_status_word_low) begin
      status_word_low_next = status_word_low_w[7:0];
    end
  end

  // ============================================================
  // Read path
  always_comb begin
    case (sfr_sel_i)
      `IPRC_SEL_MK0: rdata_next = mask_reg[15:0];
      `IPRC_SEL_MK1: rdata_next = mask_reg[31:16];
      `IPRC_SEL_IN_SERVICE_LEVEL: rdata_next = {8'h00, in_service_level_reg};
      `IPRC_SEL_IMC: rdata_next = {8'h00, imc_reg};
      `IPRC_SEL_WDM: rdata_next = {8'h00, wdm_reg};
      `IPRC_SEL_STATUS_WORD_LOW: rdata_next = {8'h00, status_word_low_reg};
      default: rdata_next = 16'h0000;
    endcase
  end

  // ============================================================
  // Registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mask_reg <= {`IPRC_MK_RESET, `IPRC_MK_RESET};
      in_service_level_reg <= `IPRC_IN_SERVICE_LEVEL_RESET;
      imc_reg <= `IPRC_IMC_RESET;
      wdm_reg <= `IPRC_WDM_RESET;
      status_word_low_reg <= `IPRC_STATUS_WORD_LOW_RESET;
    end else begin
      mask_reg <= mask_next;
      in_service_level_reg <= in_service_level_next;
      imc_reg <= imc_next;
      wdm_reg <= wdm_next;
      status_word_low_reg <= status_word_low_next;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sfr_rdata_o <= 16'h0000;
      irq_eligible_o <= 32'h0000_0000;
      psw_push_o <= 1'b0;
      psw_bank_save_o <= 1'b0;
      psw_save_data_o <= 8'h00;
      bank_sel_o <= 3'h0;
      op_err_o <= 1'b0;
      op_err_pc_o <= 20'h00000;
    end else begin
      sfr_rdata_o <= rdata_next;
      irq_eligible_o <= eligible_next;
      psw_push_o <= push_next;
      psw_bank_save_o <= bank_next;
      psw_save_data_o <= status_word_low_reg;
      bank_sel_o <= software_context_switch_instruction_i ? software_context_switch_instruction_bank_i : bank_sel_o;
      op_err_o <= op_err_next;
      op_err_pc_o <= op_err_next ? instr_addr_i : op_err_pc_o;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      vector_load_o <= 1'b0;
      vector_addr_o <= 16'h0000;
      pc_high_o <= 4'h0;
    end else begin
      vector_load_o <= brk_i;
      vector_addr_o <= brk_i ? `IPRC_BRK_VECTOR : vector_addr_o;
      pc_high_o <= `IPRC_BRK_PC_HIGH;
    end
  end

  assign in_service_level_o = in_service_level_reg;
  assign nest_lowest_o = imc_reg[`IPRC_NEST_BIT];
  assign nmi_order_o = wdm_reg[`IPRC_PRC_BIT];
  assign ie_o = status_word_low_reg[`IPRC_IE_BIT];

  // ============================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  mask_refuse_a: assert property (
    (mask_reg == 32'hFFFF_FFFF) |=> (irq_eligible_o == 32'h0000_0000))
    else $error("Masked source offered");
  mask_view_a: assert property (
    mask_src_wr_i |=> mask_reg[$past(mask_src_idx_i)] == $past(mask_src_val_i))
    else $error("Per-source mask write lost");
  in_service_level_set_a: assert property (
    ack_mask_i |=> in_service_level_reg[$past(ack_level_i)])
    else $error("Level bit not set on ack");
  nmi_set_a: assert property (
    ack_nmi_i && ack_nmi_wdt_i |=> in_service_level_reg[`IPRC_WDTS_BIT])
    else $error("Watchdog in-service bit not set");
  in_service_level_clear_a: assert property (
    ret_clears && in_service_level_reg != 8'h00 && !ack_mask_i && !ack_nmi_i
    |=> $countones(in_service_level_reg) == $countones($past(in_service_level_reg)) - 1)
    else $error("Return did not clear exactly one bit");
  in_service_level_keep_a: assert property (
    ret_i && (ret_kind_i == RK_BRK || ret_kind_i == RK_SW_CS) && !ack_mask_i && !ack_nmi_i
    |=> $stable(in_service_level_reg))
    else $error("In-service changed on break or software return");
  in_service_level_ro_a: assert property (
    sfr_wr_i && sfr_sel_i == `IPRC_SEL_IN_SERVICE_LEVEL && !ack_mask_i && !ack_nmi_i && !ret_i
    |=> $stable(in_service_level_reg))
    else $error("In-service register took a write");
  wdm_guard_a: assert property (
    wdm_ded_i && (wdm_op3_i != ~wdm_op4_i)
    |=> op_err_o && $stable(wdm_reg) && op_err_pc_o == $past(instr_addr_i))
    else $error("Bad complement not trapped");
  wdm_other_a: assert property (
    sfr_wr_i && sfr_sel_i == `IPRC_SEL_WDM && !wdm_ded_i |=> $stable(wdm_reg) && !op_err_o)
    else $error("Ordinary write reached watchdog mode");
  brk_entry_a: assert property (
    brk_i |=> !ie_o && psw_push_o && vector_load_o && vector_addr_o == `IPRC_BRK_VECTOR)
    else $error("Break entry sequence wrong");

  // ============================================================
  // Reset values, seen at the first edge after release
  reset_mask_a: assert property (
    $rose(reset_n_i) |-> mask_reg == {`IPRC_MK_RESET, `IPRC_MK_RESET})
    else $error("Mask words not all set after reset");
  reset_levels_a: assert property (
    $rose(reset_n_i) |-> in_service_level_reg == `IPRC_IN_SERVICE_LEVEL_RESET)
    else $error("In-service levels not clear after reset");
  reset_mode_a: assert property (
    $rose(reset_n_i) |-> imc_reg == `IPRC_IMC_RESET)
    else $error("Mode control wrong after reset");
  reset_wdog_a: assert property (
    $rose(reset_n_i) |-> wdm_reg == `IPRC_WDM_RESET)
    else $error("Watchdog mode wrong after reset");
  reset_status_a: assert property (
    $rose(reset_n_i) |-> status_word_low_reg == `IPRC_STATUS_WORD_LOW_RESET && !ie_o)
    else $error("Status low wrong after reset");

  // ============================================================
  // Mask words; the gate is registered, so it trails the mask by a cycle
  mask_gate_a: assert property (
    1'b1 |=> irq_eligible_o == ($past(irq_req_i) & ~$past(mask_reg)))
    else $error("Unmasked request not offered");
  mask_byte_a: assert property (
    wr_mk0 && sfr_kind_i == WK_LOW && !mask_src_wr_i
    |=> mask_reg[15:0] == {$past(mask_reg[15:8]), $past(sfr_wdata_i[7:0])})
    else $error("Low byte write spilled");
  mask_hold_a: assert property (
    !sfr_wr_i && !mask_src_wr_i |=> $stable(mask_reg))
    else $error("Mask changed with no write");

  // ============================================================
  // In-service levels; bits 7 and 6 are the pin and watchdog pair
  nmi_pin_a: assert property (
    ack_nmi_i && !ack_nmi_wdt_i |=> in_service_level_reg[`IPRC_NMIS_BIT])
    else $error("Pin in-service bit not set");
  nmi_first_a: assert property (
    ret_clears && !ack_mask_i && !ack_nmi_i && (in_service_level_reg[7:6] != 2'b00)
    |=> in_service_level_reg[3:0] == $past(in_service_level_reg[3:0]))
    else $error("Maskable level cleared before non-maskable");
  level_first_a: assert property (
    ret_clears && !ack_mask_i && !ack_nmi_i && in_service_level_reg[7:6] == 2'b00 && in_service_level_reg[0]
    |=> !in_service_level_reg[0] && in_service_level_reg[3:1] == $past(in_service_level_reg[3:1]))
    else $error("Level zero not cleared first");
  order_wdog_a: assert property (
    ret_clears && !ack_mask_i && !ack_nmi_i && in_service_level_reg[7:6] == 2'b11 && nmi_order_o
    |=> in_service_level_reg[7:6] == 2'b10)
    else $error("Watchdog level not cleared first");
  order_pin_a: assert property (
    ret_clears && !ack_mask_i && !ack_nmi_i && in_service_level_reg[7:6] == 2'b11 && !nmi_order_o
    |=> in_service_level_reg[7:6] == 2'b01)
    else $error("Pin level not cleared first");
  level_hold_a: assert property (
    !ack_mask_i && !ack_nmi_i && !ret_clears |=> $stable(in_service_level_reg))
    else $error("In-service changed with no event");
  level_zero_a: assert property (
    ack_mask_i && ack_level_i == 2'h0 |=> in_service_level_reg[0])
    else $error("Level zero bit not set");
  level_two_a: assert property (
    ack_mask_i && ack_level_i == 2'h2 |=> in_service_level_reg[2])
    else $error("Level two bit not set");

  // ============================================================
  // Mode control and watchdog mode
  mode_write_a: assert property (
    wr_imc && sfr_kind_i == WK_WORD |=> imc_reg == $past(sfr_wdata_i[7:0]))
    else $error("Mode control write lost");
  mode_hold_a: assert property (
    !wr_imc |=> $stable(imc_reg))
    else $error("Mode control changed with no write");
  wdm_write_a: assert property (
    wdm_ded_i && wdm_match |=> wdm_reg == $past(wdm_op3_i) && !op_err_o)
    else $error("Dedicated watchdog write lost");
  wdm_hold_a: assert property (
    !wdm_ded_i |=> $stable(wdm_reg) && !op_err_o)
    else $error("Watchdog mode moved without dedicated move");
  wdm_read_a: assert property (
    sfr_sel_i == `IPRC_SEL_WDM |=> sfr_rdata_o == {8'h00, $past(wdm_reg)})
    else $error("Watchdog mode read wrong");

  // ============================================================
  // Status low save and restore
  vec_push_a: assert property (
    ack_mask_i && !ack_cs_i |=> psw_push_o && !ie_o && psw_save_data_o == $past(status_word_low_reg))
    else $error("Vectored entry did not save status");
  status_restore_a: assert property (
    ret_i && !ack_mask_i && !brk_i && !software_context_switch_instruction_i |=> status_word_low_reg == $past(restore_data_i))
    else $error("Status low not restored");
  bank_save_a: assert property (
    (ack_mask_i && ack_cs_i) || software_context_switch_instruction_i |=> psw_bank_save_o && !ie_o)
    else $error("Switch entry did not save status");
  soft_take_a: assert property (
    brk_i || software_context_switch_instruction_i |=> !ie_o && (psw_push_o || psw_bank_save_o))
    else $error("Software interrupt not taken");
  bank_pick_a: assert property (
    software_context_switch_instruction_i |=> bank_sel_o == $past(software_context_switch_instruction_bank_i))
    else $error("Switch bank not captured");
  vec_once_a: assert property (
    !brk_i |=> !vector_load_o && pc_high_o == `IPRC_BRK_PC_HIGH)
    else $error("Vector load outside break entry");

  nest_ack_c: cover property (ack_mask_i ##[1:4] ack_mask_i ##[1:8] ret_clears);
  wdm_ok_c: cover property (wdm_ded_i && wdm_match);
  software_context_switch_instruction_c: cover property (software_context_switch_instruction_i ##1 psw_bank_save_o ##[1:20] ret_i);
  nmi_pair_c: cover property (ack_nmi_i && !ack_nmi_wdt_i ##[1:4] ack_nmi_i && ack_nmi_wdt_i);

endmodule

// [testbench/iprc_core_model.sv]
// Core sequencer and interrupt source model that drives the control block
`timescale 1ns/1ps

module iprc_core_model (
  input wire logic clk_i,
  output logic sfr_wr_i, mask_src_wr_i, mask_src_val_i, ack_mask_i, ack_cs_i,
  output logic ack_nmi_i, ack_nmi_wdt_i, brk_i, software_context_switch_instruction_i, ret_i, wdm_ded_i,
  output logic [2:0] sfr_sel_i, software_context_switch_instruction_bank_i,
  output iprc_pkg::iprc_wkind_t sfr_kind_i,
  output iprc_pkg::iprc_ret_t ret_kind_i,
  output logic [3:0] sfr_bit_i,
  output logic [15:0] sfr_wdata_i,
  output logic [4:0] mask_src_idx_i,
  output logic [31:0] irq_req_i,
  output logic [1:0] ack_level_i,
  output logic [7:0] restore_data_i, wdm_op3_i, wdm_op4_i,
  output logic [19:0] instr_addr_i
);
  import iprc_pkg::*;
  // ============================================================
  // Idle levels
  initial begin
    {sfr_wr_i, mask_src_wr_i, wdm_ded_i, ret_i, software_context_switch_instruction_i, brk_i, ack_nmi_i, ack_mask_i} = 8'h00;
    {mask_src_val_i, ack_cs_i, ack_nmi_wdt_i, sfr_sel_i, software_context_switch_instruction_bank_i, sfr_bit_i} = 13'h0000;
    sfr_kind_i = WK_WORD;
    ret_kind_i = RK_VEC;
    {sfr_wdata_i, mask_src_idx_i, ack_level_i, restore_data_i} = 31'h00000000;
    {irq_req_i, wdm_op3_i, wdm_op4_i, instr_addr_i} = 68'h0;
  end
  // ============================================================
  // One request per call, raised after a falling edge and held one full cycle
  task automatic strobe(input logic [7:0] m, input logic [15:0] d, input logic [7:0] r);
    @(negedge clk_i);
    sfr_wdata_i = d;
    restore_data_i = r;
    {sfr_wr_i, mask_src_wr_i, wdm_ded_i, ret_i, software_context_switch_instruction_i, brk_i, ack_nmi_i, ack_mask_i} = m;
    @(negedge clk_i);
    {sfr_wr_i, mask_src_wr_i, wdm_ded_i, ret_i, software_context_switch_instruction_i, brk_i, ack_nmi_i, ack_mask_i} = 8'h00;
    // Released data does not keep its last value
    sfr_wdata_i = ~d;
    restore_data_i = ~r;
  endtask
endmodule

// [testbench/iprc_top_tb.sv]
// Self-checking bench for the interrupt mask and priority control block
`timescale 1ns/1ps

module iprc_top_tb;
  import iprc_pkg::*;
  typedef struct {logic [2:0] s; logic [1:0] k; logic [3:0] b; logic [15:0] d;
    logic [15:0] e;} iprc_row_t;
  logic clk_i, reset_n_i, sfr_wr_i, mask_src_wr_i, mask_src_val_i, ack_mask_i, ack_cs_i;
  logic ack_nmi_i, ack_nmi_wdt_i, brk_i, software_context_switch_instruction_i, ret_i, wdm_ded_i, nest_lowest_o;
  logic nmi_order_o, ie_o, psw_push_o, psw_bank_save_o, vector_load_o, op_err_o;
  logic [2:0] sfr_sel_i, software_context_switch_instruction_bank_i, bank_sel_o;
  iprc_wkind_t sfr_kind_i;
  iprc_ret_t ret_kind_i;
  logic [3:0] sfr_bit_i, pc_high_o;
  logic [15:0] sfr_wdata_i, sfr_rdata_o, vector_addr_o;
  logic [4:0] mask_src_idx_i;
  logic [31:0] irq_req_i, irq_eligible_o;
  logic [1:0] ack_level_i;
  logic [7:0] restore_data_i, wdm_op3_i, wdm_op4_i, in_service_level_o, psw_save_data_o;
  logic [19:0] instr_addr_i, op_err_pc_o;
  int err_total = 0;
  int checks_done = 0;
  int n_operr = 0;
  // Mode control is written while interrupts are still disabled after reset
  iprc_row_t rows [11] = '{
    '{3'h0, 2'h0, 4'h0, 16'h1234, 16'h1234}, '{3'h0, 2'h1, 4'h0, 16'h00AB, 16'h12AB},
    '{3'h0, 2'h2, 4'h0, 16'h00CD, 16'hCDAB}, '{3'h0, 2'h3, 4'h0, 16'h0000, 16'hCDAA},
    '{3'h0, 2'h3, 4'hF, 16'h0000, 16'h4DAA}, '{3'h1, 2'h0, 4'h0, 16'h00F0, 16'h00F0},
    '{3'h2, 2'h0, 4'h0, 16'h00FF, 16'h0000}, '{3'h3, 2'h0, 4'h0, 16'h0000, 16'h0000},
    '{3'h4, 2'h0, 4'h0, 16'h0055, 16'h0000}, '{3'h4, 2'h3, 4'h7, 16'h0001, 16'h0000},
    '{3'h5, 2'h1, 4'h0, 16'h0020, 16'h0020}};
  logic [15:0] rv [7] = '{16'hFFFF, 16'hFFFF, 16'h0000, 16'h0080, 16'h0000, 16'h0000, 16'h0000};

  iprc_top uut (.clk_i, .reset_n_i, .sfr_wr_i, .sfr_sel_i, .sfr_kind_i, .sfr_bit_i,
    .sfr_wdata_i, .sfr_rdata_o, .mask_src_wr_i, .mask_src_idx_i, .mask_src_val_i, .irq_req_i,
    .irq_eligible_o, .ack_mask_i, .ack_level_i, .ack_cs_i, .ack_nmi_i, .ack_nmi_wdt_i, .brk_i,
    .software_context_switch_instruction_i, .software_context_switch_instruction_bank_i, .ret_i, .ret_kind_i, .restore_data_i, .wdm_ded_i, .wdm_op3_i,
    .wdm_op4_i, .instr_addr_i, .in_service_level_o, .nest_lowest_o, .nmi_order_o, .ie_o, .psw_push_o,
    .psw_bank_save_o, .psw_save_data_o, .bank_sel_o, .vector_load_o, .vector_addr_o,
    .pc_high_o, .op_err_o, .op_err_pc_o);
  iprc_core_model core (.clk_i, .sfr_wr_i, .mask_src_wr_i, .mask_src_val_i, .ack_mask_i,
    .ack_cs_i, .ack_nmi_i, .ack_nmi_wdt_i, .brk_i, .software_context_switch_instruction_i, .ret_i, .wdm_ded_i, .sfr_sel_i,
    .software_context_switch_instruction_bank_i, .sfr_kind_i, .ret_kind_i, .sfr_bit_i, .sfr_wdata_i, .mask_src_idx_i,
    .irq_req_i, .ack_level_i, .restore_data_i, .wdm_op3_i, .wdm_op4_i, .instr_addr_i);

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (op_err_o === 1'b1) n_operr <= n_operr + 1;
  end
  // ============================================================
  // Shared tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [2:0] s, input logic [15:0] e);
    core.sfr_sel_i = s;
    @(negedge clk_i);
    chk(sfr_rdata_o, e);
  endtask
  task automatic wr(input logic [2:0] s, input logic [1:0] k, input logic [3:0] b,
    input logic [15:0] d);
    core.sfr_sel_i = s;
    core.sfr_kind_i = iprc_wkind_t'(k);
    core.sfr_bit_i = b;
    core.strobe(8'h80, d, 8'h00);
  endtask
  // q: restore enable, return kind, switch or watchdog select, level
  task automatic ev(input logic [7:0] m, input logic [6:0] q, input logic [7:0] ei,
    input logic [3:0] ef);
    core.ack_level_i = q[1:0];
    core.ack_cs_i = q[2];
    core.ack_nmi_wdt_i = q[2];
    core.ret_kind_i = iprc_ret_t'(q[5:3]);
    core.strobe(m, 16'h0000, {2'h0, q[6], 5'h00});
    chk(in_service_level_o, ei);
    chk({ie_o, psw_push_o, psw_bank_save_o, vector_load_o}, ef);
  endtask
  task automatic watchdog_mode(input logic [7:0] a, input logic [7:0] b);
    core.wdm_op3_i = a;
    core.wdm_op4_i = b;
    core.strobe(8'h20, 16'h0000, 8'h00);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ============================================================
  // Hang guard
  initial begin
    #1000000;
    err_total++;
    test_done();
  end
  // ============================================================
  // Main sequence
  initial begin
    reset_n_i = 1'b0;
    repeat (20) @(negedge clk_i);
    reset_n_i = 1'b1;
    for (int i = 0; i < 11; i++) begin
      wr(rows[i].s, rows[i].k, rows[i].b, rows[i].d);
      rd(rows[i].s, rows[i].e);
    end
    chk(n_operr, 32'h0);
    $display("register rows done");
    // Second reset in mid-run
    reset_n_i = 1'b0;
    @(negedge clk_i);
    reset_n_i = 1'b1;
    for (int s = 0; s < 7; s++) rd(3'(s), rv[s]);
    chk({nest_lowest_o, ie_o, in_service_level_o}, 10'h200);
    $display("reset values done");
    core.irq_req_i = 32'hFFFF_FFFF;
    rd(3'h1, 16'hFFFF);
    chk(irq_eligible_o, 32'h0000_0000);
    core.mask_src_idx_i = 5'h11;
    core.mask_src_val_i = 1'b0;
    core.strobe(8'h40, 16'h0000, 8'h00);
    rd(3'h1, 16'hFFFD);
    wr(3'h0, 2'h0, 4'h0, 16'hFFFE);
    rd(3'h0, 16'hFFFE);
    chk(irq_eligible_o, 32'h0002_0001);
    $display("mask tests done");
    wr(3'h5, 2'h1, 4'h0, 16'h0020);
    ev(8'h01, 7'h02, 8'h04, 4'h4);
    ev(8'h01, 7'h04, 8'h05, 4'h2);
    ev(8'h02, 7'h00, 8'h85, 4'h0);
    ev(8'h02, 7'h04, 8'hC5, 4'h0);
    ev(8'h10, 7'h00, 8'h45, 4'h0);
    watchdog_mode(8'h10, 8'hEF);
    rd(3'h4, 16'h0010);
    chk(nmi_order_o, 1'b1);
    ev(8'h02, 7'h00, 8'hC5, 4'h0);
    ev(8'h10, 7'h00, 8'h85, 4'h0);
    ev(8'h10, 7'h50, 8'h85, 4'h8);
    core.software_context_switch_instruction_bank_i = 3'h5;
    ev(8'h08, 7'h00, 8'h85, 4'h2);
    chk(bank_sel_o, 3'h5);
    ev(8'h10, 7'h58, 8'h85, 4'h8);
    ev(8'h10, 7'h08, 8'h05, 4'h0);
    ev(8'h10, 7'h00, 8'h04, 4'h0);
    ev(8'h10, 7'h60, 8'h04, 4'h8);
    ev(8'h04, 7'h00, 8'h04, 4'h5);
    chk(psw_save_data_o, 8'h20);
    chk({pc_high_o, vector_addr_o}, 20'h0003E);
    ev(8'h10, 7'h00, 8'h00, 4'h0);
    $display("event tests done");
    core.instr_addr_i = 20'hABCDE;
    watchdog_mode(8'h10, 8'hEE);
    chk({op_err_o, op_err_pc_o}, 21'h1ABCDE);
    rd(3'h4, 16'h0010);
    $display("watchdog mode tests done");
    test_done();
  end
endmodule
